// ### clkgen_pkg.sv
package clkgen_pkg;
   // ********************************************
   // Register map
   // ********************************************
   localparam logic [11:0] ADDR_CFG = 12'h000;
   localparam logic [11:0] ADDR_GATE = 12'h004;
   localparam logic [11:0] ADDR_TRIG = 12'h008;
   localparam logic [11:0] ADDR_STAT = 12'h00C;
   localparam logic [31:0] CFG_RST = 32'h0000_0107;
   localparam logic [31:0] GATE_RST = 32'hFFFF_FFFF;
   localparam logic [3:0] TRIG_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************************
   // Frequencies and timing
   // ********************************************
   localparam logic [31:0] OSC_KHZ = 32'h0000_32C8;
   localparam logic [31:0] PERIPH_PLL_KHZ = 32'h0004_C2C0;
   localparam logic [31:0] USB_DIV_NUM = 32'h0000_0002;
   localparam logic [31:0] USB_DIV_DEN = 32'h0000_000D;
   localparam logic [4:0] MEM_DIV_L_MIN = 5'h0B;
   localparam logic [4:0] LCD_DIV_L_MIN = 5'h08;
   localparam int SETTLE_US = 150;
   localparam int CLK_MHZ = 25;
   localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_US * CLK_MHZ);

   // ********************************************
   // Types
   // ********************************************
   typedef struct packed {
      logic core_pll_off;
      logic periph_pll_off;
      logic [1:0] rsv_hi;
      logic lcd_double_osc_select;
      logic pll_early;
      logic mem_fast;
      logic [14:0] rsv_mid;
      logic [2:0] turbo_ratio_doubled;
      logic [1:0] rsv_lo;
      logic [4:0] run_mult;
   } core_clock_config_t;

   typedef struct packed {
      logic fast_bus;
      logic half_speed_turbo;
      logic freq_change;
      logic turbo;
   } clock_change_trigger_t;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_STOP, SEQ_SETTLE, SEQ_APPLY} seq_t;

   typedef struct packed {
      logic [31:0] cpu_khz;
      logic [31:0] run_khz;
      logic [31:0] turbo_khz;
      logic [31:0] bus_khz;
      logic [31:0] mem_khz;
      logic [31:0] lcd_khz;
      logic [31:0] periph_khz;
      logic [31:0] usb48_khz;
      logic periph_pll_on;
      logic core_pll_on;
      logic halt;
   } clk_plan_t;

   typedef struct packed {
      core_clock_config_t cfg;
      logic [31:0] gate;
      clock_change_trigger_t trig;
      core_clock_config_t act_cfg;
      clock_change_trigger_t act_trig;
      seq_t seq;
      logic [11:0] cnt;
      logic aw_ok;
      logic w_ok;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      clk_plan_t plan;
   } state_t;
endpackage

// ### clkgen_ctrl.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module clkgen_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output clkgen_pkg::clk_plan_t plan,
   output logic [31:0] module_clk_en
);
   clkgen_pkg::state_t st_reg;
   clkgen_pkg::state_t st_next;
   clkgen_pkg::core_clock_config_t c;
   clkgen_pkg::clock_change_trigger_t tnew;
   logic [31:0] run;
   logic [31:0] turbo;
   logic wr_go;
   logic wr_map;
   logic rd_go;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ********************************************
   // Bus handshakes
   // ********************************************
   assign s_axi_awready = !st_reg.aw_ok && !st_reg.bvalid;
   assign s_axi_wready = !st_reg.w_ok && !st_reg.bvalid;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign plan = st_reg.plan;
   assign module_clk_en = st_reg.gate;

   always_comb begin
      st_next = st_reg;
      c = st_reg.act_cfg;
      tnew = st_reg.trig;
      wr_go = st_reg.aw_ok && st_reg.w_ok;
      wr_map = st_reg.awaddr == clkgen_pkg::ADDR_CFG || st_reg.awaddr == clkgen_pkg::ADDR_GATE
         || st_reg.awaddr == clkgen_pkg::ADDR_TRIG || st_reg.awaddr == clkgen_pkg::ADDR_STAT;
      rd_go = s_axi_arvalid && !st_reg.rvalid;

      // ********************************************
      // Write channel
      // ********************************************
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_ok = 1'b1;
         st_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_ok = 1'b1;
         st_next.wdata = s_axi_wdata;
         st_next.wstrb = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_next.aw_ok = 1'b0;
         st_next.w_ok = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = wr_map ? clkgen_pkg::RESP_OKAY : clkgen_pkg::RESP_SLVERR;
         case (st_reg.awaddr)
            clkgen_pkg::ADDR_CFG: begin
               st_next.cfg = merge(st_reg.cfg, st_reg.wdata, st_reg.wstrb);
            end
            clkgen_pkg::ADDR_GATE: begin
               st_next.gate = merge(st_reg.gate, st_reg.wdata, st_reg.wstrb);
            end
            clkgen_pkg::ADDR_TRIG: begin
               if (st_reg.wstrb[0]) begin
                  tnew = st_reg.wdata[3:0];
                  st_next.trig = tnew;
                  st_next.act_trig.turbo = tnew.turbo;
                  st_next.act_trig.half_speed_turbo = tnew.half_speed_turbo;
                  if (st_reg.seq == clkgen_pkg::SEQ_IDLE
                      && (tnew.freq_change || tnew.fast_bus != st_reg.act_trig.fast_bus)) begin
                     st_next.seq = clkgen_pkg::SEQ_STOP;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // ********************************************
      // Read channel
      // ********************************************
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (rd_go) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = clkgen_pkg::RESP_OKAY;
         case (s_axi_araddr)
            clkgen_pkg::ADDR_CFG: begin
               st_next.rdata = st_reg.cfg;
            end
            clkgen_pkg::ADDR_GATE: begin
               st_next.rdata = st_reg.gate;
            end
            clkgen_pkg::ADDR_TRIG: begin
               st_next.rdata = {28'h0000000, st_reg.trig};
            end
            clkgen_pkg::ADDR_STAT: begin
               st_next.rdata = {12'h000, st_reg.act_trig, st_reg.act_cfg.turbo_ratio_doubled,
                  st_reg.act_cfg.run_mult, 5'h00, st_reg.plan.core_pll_on,
                  st_reg.plan.periph_pll_on, st_reg.plan.halt};
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
               st_next.rresp = clkgen_pkg::RESP_SLVERR;
            end
         endcase
      end

      // ********************************************
      // Frequency-change sequence
      // ********************************************
      case (st_reg.seq)
         clkgen_pkg::SEQ_STOP: begin
            st_next.cnt = 12'h001;
            if (!st_reg.cfg.core_pll_off && !st_reg.cfg.pll_early) begin
               st_next.cnt = clkgen_pkg::SETTLE_CYC;
            end
            if (st_reg.act_cfg.periph_pll_off && !st_reg.cfg.periph_pll_off) begin
               st_next.cnt = clkgen_pkg::SETTLE_CYC;
            end
            st_next.seq = clkgen_pkg::SEQ_SETTLE;
         end
         clkgen_pkg::SEQ_SETTLE: begin
            st_next.cnt = st_reg.cnt - 12'h001;
            if (st_reg.cnt <= 12'h001) begin
               st_next.seq = clkgen_pkg::SEQ_APPLY;
            end
         end
         clkgen_pkg::SEQ_APPLY: begin
            st_next.act_cfg = st_reg.cfg;
            st_next.act_trig.fast_bus = st_reg.trig.fast_bus;
            st_next.seq = clkgen_pkg::SEQ_IDLE;
         end
         default: begin
         end
      endcase

      // ********************************************
      // Clock plan from the active settings and the sequence state
      // ********************************************
      run = clkgen_pkg::OSC_KHZ * {27'h0000000, c.run_mult};
      turbo = (run * {29'h00000000, c.turbo_ratio_doubled}) >> 1;
      if (c.core_pll_off) begin
         run = clkgen_pkg::OSC_KHZ;
         turbo = clkgen_pkg::OSC_KHZ;
      end
      st_next.plan.run_khz = run;
      st_next.plan.turbo_khz = turbo;
      if (st_reg.act_trig.half_speed_turbo) begin
         st_next.plan.cpu_khz = turbo >> 1;
      end else begin
         st_next.plan.cpu_khz = st_reg.act_trig.turbo ? turbo : run;
      end
      st_next.plan.bus_khz = (st_reg.act_trig.fast_bus || c.core_pll_off) ? run : run >> 1;
      st_next.plan.mem_khz = (c.run_mult >= clkgen_pkg::MEM_DIV_L_MIN && !c.mem_fast
         && !c.core_pll_off) ? run >> 1 : run;
      if (c.core_pll_off) begin
         st_next.plan.lcd_khz = c.lcd_double_osc_select ? clkgen_pkg::OSC_KHZ << 1 : clkgen_pkg::OSC_KHZ;
      end else begin
         st_next.plan.lcd_khz = c.run_mult >= clkgen_pkg::LCD_DIV_L_MIN ? run >> 1 : run;
      end
      st_next.plan.periph_khz = c.periph_pll_off ? clkgen_pkg::OSC_KHZ : clkgen_pkg::PERIPH_PLL_KHZ;
      st_next.plan.usb48_khz = c.periph_pll_off ? clkgen_pkg::OSC_KHZ
         : clkgen_pkg::PERIPH_PLL_KHZ * clkgen_pkg::USB_DIV_NUM / clkgen_pkg::USB_DIV_DEN;
      st_next.plan.periph_pll_on = !c.periph_pll_off && st_reg.seq != clkgen_pkg::SEQ_STOP;
      st_next.plan.core_pll_on = !c.core_pll_off && st_reg.seq != clkgen_pkg::SEQ_STOP;
      st_next.plan.halt = st_next.seq != clkgen_pkg::SEQ_IDLE;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.cfg <= clkgen_pkg::CFG_RST;
         st_reg.act_cfg <= clkgen_pkg::CFG_RST;
         st_reg.gate <= clkgen_pkg::GATE_RST;
         st_reg.trig <= clkgen_pkg::TRIG_RST;
         st_reg.act_trig <= clkgen_pkg::TRIG_RST;
         st_reg.seq <= clkgen_pkg::SEQ_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ********************************************
   // Checks
   // ********************************************
   property p_periph_on;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n && !st_reg.act_cfg.periph_pll_off |=> plan.periph_khz == clkgen_pkg::PERIPH_PLL_KHZ;
   endproperty
   a_periph_on: assert property (p_periph_on) else $error("periph source not 312 MHz");

   property p_periph_off;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.act_cfg.periph_pll_off |=> plan.periph_khz == clkgen_pkg::OSC_KHZ && plan.usb48_khz == clkgen_pkg::OSC_KHZ;
   endproperty
   a_periph_off: assert property (p_periph_off) else $error("periph not on oscillator");

   property p_settle;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.seq == clkgen_pkg::SEQ_STOP && st_reg.act_cfg.periph_pll_off && !st_reg.cfg.periph_pll_off
         |=> st_reg.cnt == clkgen_pkg::SETTLE_CYC && st_reg.seq == clkgen_pkg::SEQ_SETTLE;
   endproperty
   a_settle: assert property (p_settle) else $error("settle wait not loaded");

   property p_usb;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n && !st_reg.act_cfg.periph_pll_off
         |=> plan.usb48_khz * 32'h0000_000D == plan.periph_khz * 32'h0000_0002;
   endproperty
   a_usb: assert property (p_usb) else $error("48 MHz ratio wrong");

   property p_run;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n && !st_reg.act_cfg.core_pll_off
         |=> plan.run_khz == clkgen_pkg::OSC_KHZ * {27'h0, $past(st_reg.act_cfg.run_mult)};
   endproperty
   a_run: assert property (p_run) else $error("run frequency wrong");

   property p_core_off;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.act_cfg.core_pll_off |=> plan.cpu_khz <= clkgen_pkg::OSC_KHZ && plan.bus_khz == clkgen_pkg::OSC_KHZ;
   endproperty
   a_core_off: assert property (p_core_off) else $error("core not on oscillator");

   property p_gate;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.bvalid && !$past(st_reg.bvalid) && $past(st_reg.awaddr) == clkgen_pkg::ADDR_GATE
         && $past(st_reg.wstrb) == 4'hF |-> module_clk_en == $past(st_reg.wdata);
   endproperty
   a_gate: assert property (p_gate) else $error("gate write not applied");

   property p_trigger;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.seq == clkgen_pkg::SEQ_IDLE && wr_go && st_reg.awaddr == clkgen_pkg::ADDR_TRIG
         && st_reg.wstrb[0] && st_reg.wdata[1] |=> st_reg.seq == clkgen_pkg::SEQ_STOP ##1 plan.halt;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger did not start change");

   property p_cfg_only;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.seq == clkgen_pkg::SEQ_IDLE && !(wr_go && st_reg.awaddr == clkgen_pkg::ADDR_TRIG)
         |=> $stable(st_reg.act_cfg);
   endproperty
   a_cfg_only: assert property (p_cfg_only) else $error("clock changed without trigger");

   property p_bus;
      @(posedge core_clk) disable iff (!rst_n)
      rst_n && !st_reg.act_cfg.core_pll_off && !st_reg.act_trig.fast_bus |=> plan.bus_khz == plan.run_khz >> 1;
   endproperty
   a_bus: assert property (p_bus) else $error("bus not half run");

   property p_half_turbo;
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.act_trig.half_speed_turbo |=> plan.cpu_khz == plan.turbo_khz >> 1;
   endproperty
   a_half_turbo: assert property (p_half_turbo) else $error("half turbo wrong");
endmodule

// ### gated_periph_model.sv
`timescale 1ns/100ps
// ************************************
// Peripheral behind one clock enable bit
// ************************************
module gated_periph_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   output logic [31:0] rd_data
);
   logic [31:0] data_reg;
   logic [31:0] noise_reg;

   // Writes land only while the module clock runs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= 32'h0000_0000;
         noise_reg <= 32'h0000_0000;
      end else begin
         noise_reg <= ~noise_reg;
         if (clk_en && wr_en) begin
            data_reg <= wr_data;
         end
      end
   end

   // Gated reads give a value that changes every cycle
   assign rd_data = clk_en ? data_reg : noise_reg;
endmodule

// ### pll_clock_generation_and_gating_tb.sv
`timescale 1ns/100ps
module pll_clock_generation_and_gating_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   clkgen_pkg::clk_plan_t plan;
   logic [31:0] module_clk_en;
   logic periph_wr = 1'b0;
   logic [31:0] periph_wdata = 32'h0000_0000;
   logic [31:0] periph_rdata;
   clkgen_pkg::core_clock_config_t cfg;
   int miscompares = 0;
   int cmp_count = 0;

   always #20 core_clk = ~core_clk;

   clkgen_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .plan(plan), .module_clk_en(module_clk_en));

   gated_periph_model i_periph (.core_clk(core_clk), .rst_n(rst_n), .clk_en(module_clk_en[0]),
      .wr_en(periph_wr), .wr_data(periph_wdata), .rd_data(periph_rdata));

   // ************************************
   // Bus cycles and comparison
   // ************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hs;
      logic w_hs;
      logic done;
      done = 1'b0;
      r = 2'h3;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(negedge core_clk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid && s_axi_bready;
         if (done) r = s_axi_bresp;
         @(posedge core_clk);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
      end
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hs;
      logic done;
      done = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(negedge core_clk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk);
         if (ar_hs) s_axi_arvalid <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      check("bresp", 32'(r), 32'(clkgen_pkg::RESP_OKAY));
   endtask

   // Counts the cycles a change sequence holds halt high
   task automatic count_halt(output int n);
      int k;
      n = 0;
      for (k = 0; k < 5000; k++) begin
         @(negedge core_clk);
         if (plan.halt === 1'b1) n++;
         else if (n > 0) break;
      end
   endtask

   task automatic trig(input logic [31:0] d, output int n);
      fork
         wr(clkgen_pkg::ADDR_TRIG, d);
         count_halt(n);
      join
      // Plan follows the active settings one edge later
      @(negedge core_clk);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ************************************
   // Scenarios
   // ************************************
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      logic [31:0] run;
      run = clkgen_pkg::OSC_KHZ * 32'h7;
      axi_rd(clkgen_pkg::ADDR_CFG, d, r);
      check("cfg reset", d, clkgen_pkg::CFG_RST);
      axi_rd(clkgen_pkg::ADDR_GATE, d, r);
      check("gate reset", d, clkgen_pkg::GATE_RST);
      axi_rd(12'h010, d, r);
      check("unmapped rresp", 32'(r), 32'(clkgen_pkg::RESP_SLVERR));
      check("unmapped rdata", d, 32'h0000_0000);
      axi_wr(12'h010, 32'h0000_1234, r);
      check("unmapped bresp", 32'(r), 32'(clkgen_pkg::RESP_SLVERR));
      wr(clkgen_pkg::ADDR_STAT, 32'hFFFF_FFFF);
      @(negedge core_clk);
      check("run reset", plan.run_khz, run);
      check("turbo reset", plan.turbo_khz, run);
      check("bus reset", plan.bus_khz, run / 32'h2);
      check("periph reset", plan.periph_khz, clkgen_pkg::PERIPH_PLL_KHZ);
      check("usb reset", plan.usb48_khz, clkgen_pkg::PERIPH_PLL_KHZ * 32'h2 / 32'hD);
      check("core on", 32'(plan.core_pll_on), 32'h1);
   endtask

   task automatic t_change;
      logic [31:0] run;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      run = clkgen_pkg::OSC_KHZ * 32'h10;
      cfg = clkgen_pkg::CFG_RST;
      cfg.run_mult = 5'h10;
      cfg.turbo_ratio_doubled = 3'h4;
      cfg.pll_early = 1'b1;
      wr(clkgen_pkg::ADDR_CFG, cfg);
      repeat (3) @(negedge core_clk);
      check("run before trigger", plan.run_khz, clkgen_pkg::OSC_KHZ * 32'h7);
      check("halt before trigger", 32'(plan.halt), 32'h0);
      trig(32'h0000_000A, n);
      check("early settle", 32'(n >= 1 && n <= 8), 32'h1);
      check("run", plan.run_khz, run);
      check("turbo", plan.turbo_khz, run * 32'h2);
      check("fast bus", plan.bus_khz, run);
      check("mem", plan.mem_khz, run / 32'h2);
      check("lcd", plan.lcd_khz, run / 32'h2);
      check("cpu run", plan.cpu_khz, run);
      axi_rd(clkgen_pkg::ADDR_STAT, d, r);
      check("active mult", 32'(d[12:8]), 32'h10);
      wr(clkgen_pkg::ADDR_TRIG, 32'h0000_0009);
      repeat (2) @(negedge core_clk);
      check("cpu turbo", plan.cpu_khz, run * 32'h2);
      check("turbo no halt", 32'(plan.halt), 32'h0);
      wr(clkgen_pkg::ADDR_TRIG, 32'h0000_000D);
      repeat (2) @(negedge core_clk);
      check("cpu half", plan.cpu_khz, run);
   endtask

   task automatic t_off_on;
      int n;
      // Both PLLs go off together, never core on with peripheral off
      cfg.core_pll_off = 1'b1;
      cfg.periph_pll_off = 1'b1;
      cfg.lcd_double_osc_select = 1'b1;
      wr(clkgen_pkg::ADDR_CFG, cfg);
      trig(32'h0000_0002, n);
      check("periph off", plan.periph_khz, clkgen_pkg::OSC_KHZ);
      check("usb off", plan.usb48_khz, clkgen_pkg::OSC_KHZ);
      check("periph pll", 32'(plan.periph_pll_on), 32'h0);
      check("core pll", 32'(plan.core_pll_on), 32'h0);
      check("cpu osc", plan.cpu_khz, clkgen_pkg::OSC_KHZ);
      check("bus osc", plan.bus_khz, clkgen_pkg::OSC_KHZ);
      check("lcd osc", plan.lcd_khz, clkgen_pkg::OSC_KHZ * 32'h2);
      cfg.core_pll_off = 1'b0;
      cfg.periph_pll_off = 1'b0;
      cfg.pll_early = 1'b0;
      wr(clkgen_pkg::ADDR_CFG, cfg);
      trig(32'h0000_0002, n);
      check("settle", 32'(n >= 3750 && n <= 3760), 32'h1);
      check("periph back", plan.periph_khz, clkgen_pkg::PERIPH_PLL_KHZ);
      check("core back", 32'(plan.core_pll_on), 32'h1);
      check("slow bus", plan.bus_khz, clkgen_pkg::OSC_KHZ * 32'h8);
   endtask

   task automatic periph_write(input logic [31:0] d);
      @(posedge core_clk);
      periph_wr <= 1'b1;
      periph_wdata <= d;
      @(posedge core_clk);
      periph_wr <= 1'b0;
   endtask

   task automatic t_gate;
      wr(clkgen_pkg::ADDR_GATE, 32'h0000_0001);
      @(negedge core_clk);
      check("gate on", module_clk_en, 32'h0000_0001);
      periph_write(32'h5A5A_0001);
      wr(clkgen_pkg::ADDR_GATE, 32'h0000_0000);
      @(negedge core_clk);
      check("gate off", module_clk_en, 32'h0000_0000);
      periph_write(32'h0000_0BAD);
      wr(clkgen_pkg::ADDR_GATE, 32'h8000_0001);
      @(negedge core_clk);
      check("gate mix", module_clk_en, 32'h8000_0001);
      check("periph kept", periph_rdata, 32'h5A5A_0001);
   endtask

   initial begin
      #(40 * 40000);
      miscompares++;
      wrap_up();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_change();
      t_off_on();
      t_gate();
      wrap_up();
   end
endmodule
